// ===== pkg/fsp_pkg.sv
// Constants and types shared by the framed serial port design files.
// Assumes a single 25 MHz clock domain and plain-port configuration.
package fsp_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int WORD_W = 16;
  localparam int DEPTH = 16;
  localparam int LVL_W = 5;
  localparam int PTR_W = 4;
  localparam int SLOT_W = 2;
  localparam int BIT_W = 6;
  localparam int ST_W = 12;
  localparam int ERR_W = 5;
  localparam int PRS_W = 5;
  localparam int DIV_W = 3;
  localparam int BRG_W = 14;
  localparam logic [LVL_W-1:0] FULL_LVL = 5'h10;
  localparam logic [BIT_W-1:0] BIT_LAST = 6'h3f;
  localparam logic [3:0] IDX_FIRST = 4'h0;
  localparam logic [3:0] IDX_LAST = 4'hf;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [ST_W-1:0] STATUS_RST = 12'h000;
  localparam logic [ERR_W-1:0] ERR_RST = 5'h00;
  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int S_TXREQ = 0;
  localparam int S_TXEMP = 1;
  localparam int S_RXREQ = 2;
  localparam int S_RXFUL = 3;
  localparam int S_TXCTL = 4;
  localparam int S_RXCTL = 5;
  localparam int S_ERR0 = 6;
  localparam int S_SLOTERR = 11;
  // Sticky error positions inside the error vector
  localparam int E_TUDF = 0;
  localparam int E_TOVF = 1;
  localparam int E_ROVF = 2;
  localparam int E_RUDF = 3;
  localparam int E_SYNCERR = 4;
  typedef enum logic [1:0] {FSP_IDLE = 2'b00, FSP_ARMED = 2'b01, FSP_RUN = 2'b10} fsp_state_t;
endpackage

// ===== pkg/fsp_fifo_if.sv
// Connection between the port core and one of its data FIFOs.
// Assumes the FIFO and its user share the same clock.
`timescale 1ns/1ps
interface fsp_fifo_if;
  import fsp_pkg::*;
  logic push;
  logic [WORD_W-1:0] push_data;
  logic pop;
  logic [WORD_W-1:0] pop_data;
  logic flush;
  logic [LVL_W-1:0] level;
  logic full;
  logic empty;
  modport store (input push, push_data, pop, flush, output pop_data, level, full, empty);
  modport user (output push, push_data, pop, flush, input pop_data, level, full, empty);
endinterface

// ===== rtl/fsp_fifo.sv
// Sixteen-word data FIFO used for both transmit and receive.
// Assumes the user never relies on a push while full or pop while empty.
`timescale 1ns/1ps
module fsp_fifo (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  fsp_fifo_if.store f
);
  import fsp_pkg::*;
  logic [WORD_W-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [LVL_W-1:0] cnt_reg, cnt_next;
  logic do_push, do_pop;

  always_comb
  begin
    do_push = f.push && !f.full;
    do_pop = f.pop && !f.empty;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (f.flush)
    begin
      wr_next = '0;
      rd_next = '0;
      cnt_next = '0;
    end
    else
    begin
      if (do_push)
        wr_next = wr_reg + 1'b1;
      if (do_pop)
        rd_next = rd_reg + 1'b1;
      cnt_next = cnt_reg + LVL_W'(do_push) - LVL_W'(do_pop);
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset; the count guards every read
  always_ff @(posedge mclk)
  begin
    if (clk_en && do_push && !f.flush)
      mem_reg[wr_reg] <= f.push_data;
  end

  assign f.pop_data = mem_reg[rd_reg];
  assign f.level = cnt_reg;
  assign f.full = (cnt_reg == FULL_LVL);
  assign f.empty = (cnt_reg == '0);

  a_fifo_count_bound: assert property (@(posedge mclk) disable iff (reset)
    cnt_reg <= FULL_LVL) else $error("FIFO count above depth");
endmodule

// ===== rtl/fsp_brg.sv
// Baud-rate generator: divides mclk into the master serial clock.
// Assumes init is held for at least one enabled cycle to restart it.
`timescale 1ns/1ps
module fsp_brg (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic run,
  input wire logic init,
  input wire logic src_sel,
  input wire logic [fsp_pkg::PRS_W-1:0] prescale,
  input wire logic [fsp_pkg::DIV_W-1:0] divider,
  output logic sclk,
  output logic fall_tick,
  output logic rise_tick
);
  import fsp_pkg::*;
  logic [BRG_W-1:0] cnt_reg, cnt_next, half;
  logic sclk_reg, sclk_next, wrap;

  always_comb
  begin
    half = (BRG_W'(prescale) + 14'h0001) << divider;
    if (!src_sel)
      half = half << 1;
    wrap = run && !init && (cnt_reg >= half - 14'h0001);
    cnt_next = cnt_reg + 14'h0001;
    sclk_next = sclk_reg;
    if (init || !run)
    begin
      cnt_next = '0;
      sclk_next = 1'b0;
    end
    else if (wrap)
    begin
      cnt_next = '0;
      sclk_next = !sclk_reg;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cnt_reg <= '0;
      sclk_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_reg <= cnt_next;
      sclk_reg <= sclk_next;
    end
  end

  assign sclk = sclk_reg;
  assign fall_tick = wrap && sclk_reg;
  assign rise_tick = wrap && !sclk_reg;
endmodule

// ===== rtl/fsp_top.sv
// Framed serial port core: FIFOs, slot sequencer, status and interrupt.
// Assumes all inputs, pins included, are synchronous to mclk.
// Behaviour
// - Tx request while tx level reaches threshold
// - Tx empty flag; software waits on it
// - Rx request while rx level reaches threshold
// - Rx full flag when no entry free
// - Tx control ready while its register free
// - Rx control ready while captured word valid
// - Tx underflow when slot finds FIFO empty
// - Tx overflow when writing a full FIFO
// - Rx overflow when word arrives, FIFO full
// - Rx underflow when reading an empty FIFO
// - Slave frame sync early raises sync error
// - Same slot for data and control errors
// - Interrupt when any enabled status bit set
// - Clock generator runs; pin waits for start
// - Serial traffic starts at first tx write
// - Tx data shifts out aligned to sync
// - Clear transmit, then sync enable, to stop
`timescale 1ns/1ps
module fsp_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic mode_slave,
  input wire logic bit_clock_enable,
  input wire logic frame_sync_enable,
  input wire logic transmit_enable,
  input wire logic receive_enable,
  input wire logic tx_channel_reset,
  input wire logic rx_channel_reset,
  input wire logic master_clock_source_sel,
  input wire logic [fsp_pkg::PRS_W-1:0] prescale_field,
  input wire logic [fsp_pkg::DIV_W-1:0] divider_field,
  input wire logic [fsp_pkg::SLOT_W-1:0] tx_slot,
  input wire logic [fsp_pkg::SLOT_W-1:0] rx_slot,
  input wire logic [fsp_pkg::SLOT_W-1:0] ctrl_slot,
  input wire logic [fsp_pkg::LVL_W-1:0] tx_threshold,
  input wire logic [fsp_pkg::LVL_W-1:0] rx_threshold,
  input wire logic [fsp_pkg::ST_W-1:0] irq_enable_reg,
  input wire logic [fsp_pkg::ST_W-1:0] status_clr,
  input wire logic tx_data_wr,
  input wire logic [fsp_pkg::WORD_W-1:0] tx_data_in,
  input wire logic rx_data_rd,
  output logic [fsp_pkg::WORD_W-1:0] rx_data_out,
  input wire logic tx_ctrl_wr,
  input wire logic [fsp_pkg::WORD_W-1:0] tx_ctrl_in,
  input wire logic rx_ctrl_rd,
  output logic [fsp_pkg::WORD_W-1:0] rx_ctrl_out,
  output logic [fsp_pkg::ST_W-1:0] port_status_reg,
  output logic irq,
  input wire logic serial_clk_in,
  output logic serial_clk_out,
  output logic serial_clk_oe,
  input wire logic frame_sync_in,
  output logic frame_sync_out,
  output logic frame_sync_oe,
  output logic serial_tx_pin,
  input wire logic serial_rx_in
);
  import fsp_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  fsp_state_t state_reg, state_next;
  logic [BIT_W-1:0] bit_reg, bit_next, cur;
  logic [WORD_W-1:0] tsh_reg, tsh_next, rsh_reg, rsh_next;
  logic [WORD_W-1:0] tctl_reg, tctl_next, rctl_reg, rctl_next;
  logic [WORD_W-1:0] rdat_reg, rdat_next;
  logic tvld_reg, tvld_next, rvld_reg, rvld_next;
  logic fs_seen_reg, fs_seen_next, fs_out_reg, fs_out_next;
  logic live_reg, live_next, sclk_in_reg;
  logic [ERR_W-1:0] err_reg, err_next;
  logic [ST_W-1:0] status_reg, status_now;
  logic brg_sclk, brg_fall, brg_rise, fall_tick, rise_tick, running;
  logic [SLOT_W-1:0] slot, rslot;
  logic [3:0] idx, ridx;
  logic ev_udf, ev_tovf, ev_rovf, ev_rudf, ev_frame_sync_err, ctl_load, ctl_cap;

  fsp_fifo_if tx_if ();
  fsp_fifo_if rx_if ();

  fsp_fifo u_tx_fifo (.mclk(mclk), .reset(reset), .clk_en(clk_en), .f(tx_if));
  fsp_fifo u_rx_fifo (.mclk(mclk), .reset(reset), .clk_en(clk_en), .f(rx_if));

  // Generator runs from the bit clock enable alone, ahead of any traffic
  fsp_brg u_brg (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .run(bit_clock_enable),
    .init(tx_channel_reset || rx_channel_reset),
    .src_sel(master_clock_source_sel),
    .prescale(prescale_field),
    .divider(divider_field),
    .sclk(brg_sclk),
    .fall_tick(brg_fall),
    .rise_tick(brg_rise)
  );

  // ****************************************
  // Start and stop sequencing
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      FSP_IDLE:
        if (bit_clock_enable && frame_sync_enable && (transmit_enable || receive_enable))
          state_next = FSP_ARMED;
      FSP_ARMED:
        if (!frame_sync_enable || !bit_clock_enable)
          state_next = FSP_IDLE;
        else if (tx_data_wr && transmit_enable)
          state_next = FSP_RUN;
      FSP_RUN:
        if (!frame_sync_enable || !bit_clock_enable)
          state_next = FSP_IDLE;
      default:
        state_next = FSP_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      state_reg <= FSP_IDLE;
    else if (clk_en)
      state_reg <= state_next;
  end

  assign running = (state_reg == FSP_RUN);
  // Slave edges come from the pin; the previous sample only serves as history
  assign fall_tick = running && (mode_slave ? (sclk_in_reg && !serial_clk_in) : brg_fall);
  assign rise_tick = running && live_reg &&
    (mode_slave ? (!sclk_in_reg && serial_clk_in) : brg_rise);

  // ****************************************
  // Slot sequencer and data path
  // ****************************************
  always_comb
  begin
    bit_next = bit_reg;
    tsh_next = tsh_reg;
    rsh_next = rsh_reg;
    tctl_next = tctl_reg;
    rctl_next = rctl_reg;
    rdat_next = rdat_reg;
    tvld_next = tvld_reg;
    rvld_next = rvld_reg;
    fs_seen_next = fs_seen_reg;
    fs_out_next = fs_out_reg;
    live_next = live_reg;
    ev_udf = 1'b0;
    ev_rovf = 1'b0;
    ev_frame_sync_err = 1'b0;
    ctl_load = 1'b0;
    ctl_cap = 1'b0;
    tx_if.push = tx_data_wr;
    tx_if.push_data = tx_data_in;
    tx_if.pop = 1'b0;
    tx_if.flush = tx_channel_reset;
    rx_if.push = 1'b0;
    rx_if.push_data = {rsh_reg[WORD_W-2:0], serial_rx_in};
    rx_if.pop = rx_data_rd;
    rx_if.flush = rx_channel_reset;
    ev_tovf = tx_data_wr && tx_if.full;
    ev_rudf = rx_data_rd && rx_if.empty;
    if (rx_data_rd && !rx_if.empty)
      rdat_next = rx_if.pop_data;
    // An incoming sync marks the bit now starting as bit zero
    cur = (mode_slave && frame_sync_in) ? '0 : bit_reg + 1'b1;
    slot = cur[BIT_W-1:4];
    idx = cur[3:0];
    rslot = bit_reg[BIT_W-1:4];
    ridx = bit_reg[3:0];
    if (fall_tick)
    begin
      bit_next = cur;
      live_next = 1'b1;
      fs_out_next = (cur == '0);
      ev_frame_sync_err = mode_slave && frame_sync_in && fs_seen_reg && (bit_reg != BIT_LAST);
      if (mode_slave && frame_sync_in)
        fs_seen_next = 1'b1;
      tsh_next = {tsh_reg[WORD_W-2:0], 1'b0};
      if (idx == IDX_FIRST)
      begin
        if (slot == tx_slot && transmit_enable)
        begin
          if (tx_if.empty)
          begin
            ev_udf = 1'b1;
            tsh_next = WORD_RST;
          end
          else
          begin
            tx_if.pop = 1'b1;
            tsh_next = tx_if.pop_data;
          end
        end
        else if (slot == ctrl_slot)
        begin
          ctl_load = 1'b1;
          tsh_next = tvld_reg ? tctl_reg : WORD_RST;
        end
        else
          tsh_next = WORD_RST;
      end
    end
    if (rise_tick)
    begin
      rsh_next = rx_if.push_data;
      if (ridx == IDX_LAST && rslot == rx_slot && receive_enable)
      begin
        if (rx_if.full)
          ev_rovf = 1'b1;
        else
          rx_if.push = 1'b1;
      end
      else if (ridx == IDX_LAST && rslot == ctrl_slot)
      begin
        ctl_cap = 1'b1;
        rctl_next = rx_if.push_data;
      end
    end
    // A write in the same cycle as the slot load is kept
    if (ctl_load)
      tvld_next = 1'b0;
    if (tx_ctrl_wr && (!tvld_reg || ctl_load))
    begin
      tctl_next = tx_ctrl_in;
      tvld_next = 1'b1;
    end
    if (rx_ctrl_rd)
      rvld_next = 1'b0;
    if (ctl_cap)
      rvld_next = 1'b1;
    // Cleared at the edge that leaves RUN, so sync never outlives the run
    if (state_next != FSP_RUN)
    begin
      bit_next = BIT_LAST;
      fs_seen_next = 1'b0;
      fs_out_next = 1'b0;
      live_next = 1'b0;
    end
    if (tx_channel_reset)
    begin
      tsh_next = WORD_RST;
      tvld_next = 1'b0;
    end
    if (rx_channel_reset)
    begin
      rsh_next = WORD_RST;
      rvld_next = 1'b0;
    end
    // Hardware set wins over a clear in the same cycle
    err_next = (err_reg & ~status_clr[S_ERR0 +: ERR_W]) |
      {ev_frame_sync_err, ev_rudf, ev_rovf, ev_tovf, ev_udf};
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      bit_reg <= BIT_LAST;
      tsh_reg <= WORD_RST;
      rsh_reg <= WORD_RST;
      tctl_reg <= WORD_RST;
      rctl_reg <= WORD_RST;
      rdat_reg <= WORD_RST;
      tvld_reg <= 1'b0;
      rvld_reg <= 1'b0;
      fs_seen_reg <= 1'b0;
      fs_out_reg <= 1'b0;
      live_reg <= 1'b0;
      sclk_in_reg <= 1'b0;
      err_reg <= ERR_RST;
    end
    else if (clk_en)
    begin
      bit_reg <= bit_next;
      tsh_reg <= tsh_next;
      rsh_reg <= rsh_next;
      tctl_reg <= tctl_next;
      rctl_reg <= rctl_next;
      rdat_reg <= rdat_next;
      tvld_reg <= tvld_next;
      rvld_reg <= rvld_next;
      fs_seen_reg <= fs_seen_next;
      fs_out_reg <= fs_out_next;
      live_reg <= live_next;
      sclk_in_reg <= serial_clk_in;
      err_reg <= err_next;
    end
  end

  // ****************************************
  // Status and interrupt
  // ****************************************
  always_comb
  begin
    status_now = STATUS_RST;
    status_now[S_TXREQ] = (tx_if.level >= tx_threshold);
    status_now[S_TXEMP] = tx_if.empty;
    status_now[S_RXREQ] = (rx_if.level >= rx_threshold);
    status_now[S_RXFUL] = rx_if.full;
    status_now[S_TXCTL] = !tvld_reg;
    status_now[S_RXCTL] = rvld_reg;
    status_now[S_ERR0 +: ERR_W] = err_reg;
    status_now[S_SLOTERR] = (tx_slot == ctrl_slot) || (rx_slot == ctrl_slot);
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      status_reg <= STATUS_RST;
    else if (clk_en)
      status_reg <= status_now;
  end

  // Single request line, gated per source
  assign irq = |(status_reg & irq_enable_reg);
  assign port_status_reg = status_reg;
  // Clock pin held low until traffic really starts
  assign serial_clk_out = running && brg_sclk && !mode_slave;
  assign serial_clk_oe = !mode_slave;
  assign frame_sync_out = fs_out_reg && !mode_slave;
  assign frame_sync_oe = !mode_slave;
  assign serial_tx_pin = tsh_reg[WORD_W-1];
  assign rx_data_out = rdat_reg;
  assign rx_ctrl_out = rctl_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Sampled reset keeps the release edge out; status still shows its reset value there
  a_tx_req_flag: assert property (clk_en && !reset |=> port_status_reg[S_TXREQ] ==
    ($past(tx_if.level) >= $past(tx_threshold))) else $error("tx request wrong");
  a_tx_empty_flag: assert property (clk_en && !reset |=> port_status_reg[S_TXEMP] ==
    ($past(tx_if.level) == '0)) else $error("tx empty wrong");
  a_rx_req_flag: assert property (clk_en && !reset |=> port_status_reg[S_RXREQ] ==
    ($past(rx_if.level) >= $past(rx_threshold))) else $error("rx request wrong");
  a_rx_full_flag: assert property (clk_en && rx_if.level == FULL_LVL |=>
    port_status_reg[S_RXFUL]) else $error("rx full missing");
  a_tx_ctrl_ready: assert property (clk_en && tx_ctrl_wr && !tvld_reg |=>
    !status_now[S_TXCTL]) else $error("tx control still ready");
  a_rx_ctrl_valid: assert property (clk_en && ctl_cap |=>
    rvld_reg ##1 (!clk_en || port_status_reg[S_RXCTL])) else $error("rx control not flagged");
  a_tx_underflow: assert property (clk_en && fall_tick && idx == IDX_FIRST &&
    slot == tx_slot && transmit_enable && tx_if.empty |=> err_reg[E_TUDF])
    else $error("tx underflow missed");
  a_tx_overflow: assert property (clk_en && tx_data_wr && tx_if.full |=>
    err_reg[E_TOVF] && $stable(tx_if.level)) else $error("tx overflow missed");
  a_rx_overflow: assert property (clk_en && rise_tick && ridx == IDX_LAST &&
    rslot == rx_slot && receive_enable && rx_if.full |=> err_reg[E_ROVF])
    else $error("rx overflow missed");
  a_rx_underflow: assert property (clk_en && rx_data_rd && rx_if.empty |=>
    err_reg[E_RUDF] && $stable(rdat_reg)) else $error("rx underflow missed");
  a_fs_error: assert property (clk_en && fall_tick && mode_slave && frame_sync_in &&
    fs_seen_reg && bit_reg != BIT_LAST |=> err_reg[E_SYNCERR]) else $error("sync error missed");
  a_slot_clash: assert property (clk_en && tx_slot == ctrl_slot && $stable(tx_slot)
    |=> port_status_reg[S_SLOTERR]) else $error("slot clash missed");
  a_irq_output: assert property ((status_reg & irq_enable_reg) != '0 |-> irq)
    else $error("interrupt missing");
  a_clk_withheld: assert property (!running |-> !serial_clk_out)
    else $error("serial clock before start");
  a_start_on_write: assert property (state_reg == FSP_ARMED &&
    !(tx_data_wr && transmit_enable) |=> state_reg != FSP_RUN)
    else $error("started without tx write");
  a_fs_shift_sync: assert property (frame_sync_out |-> bit_reg == '0 && running)
    else $error("sync not at frame start");
  a_fs_disable_stop: assert property (clk_en && !frame_sync_enable |=>
    state_reg == FSP_IDLE ##1 !frame_sync_out) else $error("sync disable ignored");

  c_run_start: cover property (state_reg == FSP_ARMED ##1 state_reg == FSP_RUN);
  c_rx_word: cover property (clk_en && rx_if.push);
  c_ctrl_cap: cover property (clk_en && ctl_cap);
  c_irq_raise: cover property (!irq ##1 irq);
endmodule

// ===== verification/fsp_codec_model.sv
// Behavioural serial codec standing on the pins of the port in master mode.
// Assumes the port drives bit clock and sync, all sampled on mclk.
`timescale 1ns/1ps
module fsp_codec_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic fsync,
  input wire logic txd,
  output logic rxd,
  output logic [63:0] frame,
  output logic got
);
  // Fixed receive pattern, one word for each slot
  localparam logic [63:0] PAT = 64'h1234_a5c3_5a3c_8001;
  logic sclk_q;
  logic [63:0] sh;
  logic [5:0] bc;
  // Next bit is put out just after the rising clock, so it stands a full period
  assign rxd = PAT[~(bc + 6'h01)];
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sclk_q <= 1'b0;
      sh <= '0;
      bc <= 6'h3f;
      frame <= '0;
      got <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk;
      if (sclk && !sclk_q)
      begin
        sh <= {sh[62:0], txd};
        bc <= fsync ? 6'h00 : bc + 6'h01;
        // Only the first frame is kept; later ones carry underflow zeros
        if (!fsync && bc == 6'h3e && !got)
        begin
          frame <= {sh[62:0], txd};
          got <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== verification/fsp_top_tb.sv
// Self-checking bench for the framed serial port core.
// Assumes the codec model on the pins while in master mode.
`timescale 1ns/1ps
module fsp_top_tb;
  import fsp_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, clk_en = 1'b1, mode_slave = 1'b0;
  logic bit_clock_enable = 1'b0, frame_sync_enable = 1'b0;
  logic transmit_enable = 1'b0, receive_enable = 1'b0;
  logic tx_channel_reset = 1'b0, rx_channel_reset = 1'b0, master_clock_source_sel = 1'b1;
  logic [4:0] prescale_field = 5'h03;
  logic [2:0] divider_field = 3'h0;
  logic [1:0] tx_slot = 2'h0, rx_slot = 2'h1, ctrl_slot = 2'h2;
  logic [4:0] tx_threshold = 5'h02, rx_threshold = 5'h01;
  logic [11:0] irq_enable_reg = 12'h000, status_clr = 12'h000, port_status_reg;
  logic tx_data_wr = 1'b0, rx_data_rd = 1'b0, tx_ctrl_wr = 1'b0, rx_ctrl_rd = 1'b0;
  logic [15:0] tx_data_in = 16'h0000, tx_ctrl_in = 16'h0000, rx_data_out, rx_ctrl_out;
  logic irq, serial_clk_in = 1'b0, serial_clk_out, serial_clk_oe, frame_sync_in = 1'b0;
  logic frame_sync_out, frame_sync_oe, serial_tx_pin, serial_rx_in, got;
  logic [63:0] frm;
  int errors = 0;
  int cmp_count = 0;
  always #20 mclk = ~mclk;
  fsp_top dut (.mclk, .reset, .clk_en, .mode_slave, .bit_clock_enable, .frame_sync_enable,
    .transmit_enable, .receive_enable, .tx_channel_reset, .rx_channel_reset,
    .master_clock_source_sel, .prescale_field, .divider_field, .tx_slot, .rx_slot,
    .ctrl_slot, .tx_threshold, .rx_threshold, .irq_enable_reg, .status_clr, .tx_data_wr,
    .tx_data_in, .rx_data_rd, .rx_data_out, .tx_ctrl_wr, .tx_ctrl_in, .rx_ctrl_rd,
    .rx_ctrl_out, .port_status_reg, .irq, .serial_clk_in, .serial_clk_out, .serial_clk_oe,
    .frame_sync_in, .frame_sync_out, .frame_sync_oe, .serial_tx_pin, .serial_rx_in);
  fsp_codec_model codec (.mclk, .reset, .sclk(serial_clk_out), .fsync(frame_sync_out),
    .txd(serial_tx_pin), .rxd(serial_rx_in), .frame(frm), .got);
  // ****
  // Tasks
  // ****
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(input string n, input logic g, input logic e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chks(input string n, input logic [11:0] m, input logic [11:0] e);
    chk(n, {4'h0, port_status_reg & m}, {4'h0, e});
  endtask
  // Bounded wait for all masked status bits, so a hang shows as a mismatch
  task automatic wt(input string n, input logic [11:0] m, input int lim);
    int i;
    i = 0;
    while ((port_status_reg & m) !== m && i < lim)
    begin
      @(posedge mclk);
      i++;
    end
    chks(n, m, m);
  endtask
  task automatic wr_tx(input logic [15:0] d, input int n);
    for (int i = 0; i < n; i++)
    begin
      tx_data_wr <= 1'b1;
      tx_data_in <= d + 16'(i);
      @(posedge mclk);
    end
    tx_data_wr <= 1'b0;
  endtask
  task automatic pulse_rst;
    tx_channel_reset <= 1'b1;
    rx_channel_reset <= 1'b1;
    step(2);
    tx_channel_reset <= 1'b0;
    rx_channel_reset <= 1'b0;
    step(2);
  endtask
  task automatic end_sim;
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial
  begin
    step(20);
    reset <= 1'b0;
    step(2);
    chks("status reset", 12'hfff, 12'h012);
    chkb("clock idle", serial_clk_out, 1'b0);
    chkb("sync oe", frame_sync_oe, 1'b1);
    ctrl_slot <= 2'h0;
    irq_enable_reg <= 12'h800;
    step(3);
    chks("slot err", 12'h800, 12'h800);
    chkb("irq on", irq, 1'b1);
    irq_enable_reg <= 12'h400;
    step(1);
    chkb("irq masked", irq, 1'b0);
    ctrl_slot <= 2'h2;
    step(3);
    chks("slot ok", 12'h800, 12'h000);
    wr_tx(16'h1000, 1);
    step(2);
    chks("one word", 12'h003, 12'h000);
    wr_tx(16'h1001, 1);
    step(2);
    chks("two words", 12'h003, 12'h001);
    wr_tx(16'h1002, 15);
    step(2);
    chks("tx over", 12'h080, 12'h080);
    status_clr <= 12'h7c0;
    pulse_rst();
    status_clr <= 12'h000;
    step(2);
    chks("flushed", 12'h083, 12'h002);
    rx_data_rd <= 1'b1;
    step(1);
    rx_data_rd <= 1'b0;
    step(2);
    chks("rx under", 12'h200, 12'h200);
    chk("rx keep", rx_data_out, WORD_RST);
    // A frozen clock enable must hold the sticky flag against its clear
    clk_en <= 1'b0;
    status_clr <= 12'h200;
    step(3);
    chks("frozen", 12'h200, 12'h200);
    clk_en <= 1'b1;
    status_clr <= 12'h000;
    // Start sequence; the pin clock must wait for the first data word
    bit_clock_enable <= 1'b1;
    step(40);
    chkb("clock held", serial_clk_out, 1'b0);
    frame_sync_enable <= 1'b1;
    step(1);
    transmit_enable <= 1'b1;
    receive_enable <= 1'b1;
    tx_ctrl_wr <= 1'b1;
    tx_ctrl_in <= 16'hc0de;
    step(1);
    tx_ctrl_wr <= 1'b0;
    step(2);
    chks("ctrl busy", 12'h010, 12'h000);
    step(40);
    chkb("no start", serial_clk_out, 1'b0);
    wr_tx(16'hd00d, 1);
    for (int i = 0; i < 1500 && got !== 1'b1; i++)
      step(1);
    chk("tx slot", frm[63:48], 16'hd00d);
    chk("ctrl slot", frm[31:16], 16'hc0de);
    wt("ctrl free", 12'h010, 600);
    wt("tx empty", 12'h002, 600);
    wt("tx under", 12'h040, 600);
    wt("rx req", 12'h004, 1200);
    wt("rx ctrl rdy", 12'h020, 600);
    chk("rx ctrl", rx_ctrl_out, 16'h5a3c);
    rx_data_rd <= 1'b1;
    rx_ctrl_rd <= 1'b1;
    step(1);
    rx_data_rd <= 1'b0;
    rx_ctrl_rd <= 1'b0;
    step(1);
    chk("rx word", rx_data_out, 16'ha5c3);
    step(1);
    chks("rx ctrl taken", 12'h020, 12'h000);
    wt("rx full", 12'h008, 12000);
    wt("rx over", 12'h100, 1200);
    // Stop, then restart the generator through the channel resets
    transmit_enable <= 1'b0;
    step(2);
    frame_sync_enable <= 1'b0;
    receive_enable <= 1'b0;
    step(40);
    chkb("stopped", serial_clk_out, 1'b0);
    prescale_field <= 5'h00;
    divider_field <= 3'h7;
    pulse_rst();
    prescale_field <= 5'h03;
    divider_field <= 3'h0;
    step(2);
    chks("reinit", 12'h03e, 12'h012);
    // Slave mode with a sync pulse far too early in the frame
    mode_slave <= 1'b1;
    frame_sync_enable <= 1'b1;
    step(1);
    chkb("clk oe", serial_clk_oe, 1'b0);
    transmit_enable <= 1'b1;
    // One edge to reach ARMED, so the write below really starts traffic
    step(1);
    wr_tx(16'h0f0f, 1);
    for (int i = 0; i < 40; i++)
    begin
      frame_sync_in <= (i == 0 || i == 20);
      serial_clk_in <= 1'b1;
      step(4);
      serial_clk_in <= 1'b0;
      step(4);
    end
    wt("sync err", 12'h400, 50);
    end_sim();
  end
  initial
  begin
    step(60000);
    errors++;
    end_sim();
  end
endmodule
